// file: common/led_status_defs.vh
// timing and pattern code definitions for the status indicator driver
`ifndef LED_STATUS_DEFS_VH
`define LED_STATUS_DEFS_VH

// clock rate and tick period
`define CLK_HZ          20000000
`define TICK_NS         1000000
`define CLK_PERIOD_NS   50
// pattern times in milliseconds
`define BLINK_HALF_MS   11'h0c8
`define FLICKER_HALF_MS 11'h032
`define FLASH_ON_MS     11'h0c8
`define FLASH_GAP_MS    11'h0c8
`define FLASH_LONG_MS   11'h3e8

// pattern select codes
`define PAT_OFF     3'h0
`define PAT_ON      3'h1
`define PAT_BLINK   3'h2
`define PAT_FLICKER 3'h3
`define PAT_SINGLE  3'h4
`define PAT_DOUBLE  3'h5
`define PAT_TRIPLE  3'h6

`endif

// file: rtl/led_status_driver.v
// three status indicator pattern generator for a bus-to-CAN adapter
// Behaviour
// - blink is 2.5 Hz, equal on and off
// - flicker is 10 Hz, equal on and off
// - single flash 200 ms on, 1000 ms off
// - double flash, 200 ms gap, 1000 ms off
// - triple flash, 200 ms gaps, 1000 ms off
// - steady on and off have no modulation
// - yellow off until enumerated, then on
// - green blink init, single closed, on open
// - green flickers in listen-only, no transmit
// - red off without error, blink on config error
// - red single flash at error warning level
// - red steady on while bus-off
// - reset shows yellow on, green on, red off
`timescale 1ns/1ps
`include "led_status_defs.vh"

module led_status_driver
#(
  parameter TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS
)
(
  // clock, reset and enable
  input  wire sys_clk_i,
  input  wire rst_i,
  input  wire clk_en_i,
  // host and channel status
  input  wire enumerated_i,
  input  wire channel_initialised_i,
  input  wire channel_closed_i,
  input  wire channel_open_i,
  input  wire listen_only_i,
  // controller error status
  input  wire config_error_i,
  input  wire error_warning_i,
  input  wire bus_off_i,
  // indicators and transmit gate
  output reg  led_yellow_o,
  output reg  led_green_o,
  output reg  led_red_o,
  output wire tx_inhibit_o
);

  reg  [19:0] presc_reg;
  reg         tick_reg;
  reg  [2:0]  green_sel;
  reg  [2:0]  red_sel;
  wire        green_lit;
  wire        red_lit;

  // millisecond tick from the system clock
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      presc_reg <= 20'h0_0000;
      tick_reg  <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (presc_reg == TICK_CYCLES - 1)
      begin
        presc_reg <= 20'h0_0000;
        tick_reg  <= 1'b1;
      end
      else
      begin
        presc_reg <= presc_reg + 20'h0_0001;
        tick_reg  <= 1'b0;
      end
    end
  end

  // green selection from channel state
  always @*
  begin
    if (channel_open_i && listen_only_i)
      green_sel = `PAT_FLICKER;
    else if (channel_open_i)
      green_sel = `PAT_ON;
    else if (channel_initialised_i)
      green_sel = `PAT_BLINK;
    else
      green_sel = `PAT_SINGLE;
  end

  // red selection, most severe first
  always @*
  begin
    if (bus_off_i)
      red_sel = `PAT_ON;
    else if (error_warning_i)
      red_sel = `PAT_SINGLE;
    else if (config_error_i)
      red_sel = `PAT_BLINK;
    else
      red_sel = `PAT_OFF;
  end

  // listen-only keeps the controller from sending frames
  assign tx_inhibit_o = channel_open_i & listen_only_i;

  led_pattern_gen u_green
  (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .clk_en_i  (clk_en_i),
    .tick_i    (tick_reg),
    .sel_i     (green_sel),
    .lit_o     (green_lit)
  );

  led_pattern_gen u_red
  (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .clk_en_i  (clk_en_i),
    .tick_i    (tick_reg),
    .sel_i     (red_sel),
    .lit_o     (red_lit)
  );

  // registered indicator outputs
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      led_yellow_o <= 1'b1;
      led_green_o  <= 1'b1;
      led_red_o    <= 1'b0;
    end
    else if (clk_en_i)
    begin
      led_yellow_o <= enumerated_i;
      led_green_o  <= green_lit;
      led_red_o    <= red_lit;
    end
  end

endmodule

// one indicator pattern sequencer, counts in millisecond ticks
module led_pattern_gen
(
  // clock, reset and enable
  input  wire       sys_clk_i,
  input  wire       rst_i,
  input  wire       clk_en_i,
  // time base and pattern
  input  wire       tick_i,
  input  wire [2:0] sel_i,
  // lamp level
  output wire       lit_o
);

  reg  [2:0]  sel_reg;
  reg  [10:0] ms_reg;
  reg  [2:0]  phase_reg;
  reg         lit_reg;
  reg  [10:0] len;
  reg  [2:0]  last_phase;

  // phase length and index of the last phase for the pattern
  always @*
  begin
    len        = `FLASH_LONG_MS;
    last_phase = 3'h0;
    case (sel_i)
      `PAT_BLINK:
      begin
        len        = `BLINK_HALF_MS;
        last_phase = 3'h1;
      end
      `PAT_FLICKER:
      begin
        len        = `FLICKER_HALF_MS;
        last_phase = 3'h1;
      end
      `PAT_SINGLE, `PAT_DOUBLE, `PAT_TRIPLE:
      begin
        // even phases lit, odd gaps, the final phase is the long off
        len        = phase_reg[0] ? `FLASH_GAP_MS : `FLASH_ON_MS;
        last_phase = {sel_i[1:0], 1'b0} - 3'h1 + 3'h2;
        if (phase_reg == last_phase)
          len = `FLASH_LONG_MS;
      end
      default:
      begin
        len        = `FLASH_LONG_MS;
        last_phase = 3'h0;
      end
    endcase
  end

  // sequence through phases, restart when the pattern changes
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      // start from the current selection so no false lamp pulse follows
      sel_reg   <= sel_i;
      ms_reg    <= 11'h000;
      phase_reg <= 3'h0;
      lit_reg   <= (sel_i != `PAT_OFF);
    end
    else if (clk_en_i)
    begin
      sel_reg <= sel_i;
      if (sel_i != sel_reg)
      begin
        ms_reg    <= 11'h000;
        phase_reg <= 3'h0;
        lit_reg   <= (sel_i != `PAT_OFF);
      end
      else if (sel_i == `PAT_ON || sel_i == `PAT_OFF)
        lit_reg <= (sel_i == `PAT_ON);
      else if (tick_i)
      begin
        if (ms_reg == len - 11'h001)
        begin
          ms_reg <= 11'h000;
          if (phase_reg == last_phase)
          begin
            phase_reg <= 3'h0;
            lit_reg   <= 1'b1;
          end
          else
          begin
            phase_reg <= phase_reg + 3'h1;
            lit_reg   <= phase_reg[0]; // next phase even means lit
          end
        end
        else
          ms_reg <= ms_reg + 11'h001;
      end
    end
  end

  assign lit_o = lit_reg;

endmodule

// file: bench/led_lamp_model.sv
// lamp model that measures the last lit and dark spans in clocks
`timescale 1ns/1ps
module led_lamp_model
(
  // clock and lamp level
  input  wire  clk_i,
  input  wire  lamp_i,
  // last completed spans
  output int   on_len_o,
  output int   off_len_o
);
  int   run;
  logic prev;
  // count the run, latch its length when the lamp changes
  always @(posedge clk_i)
  begin
    prev <= lamp_i;
    run <= (lamp_i !== prev) ? 1 : run + 1;
    if (lamp_i !== prev && prev === 1'b1) on_len_o <= run;
    if (lamp_i !== prev && prev === 1'b0) off_len_o <= run;
  end
endmodule

// file: bench/led_status_driver_checker.sv
// port assertions for the status indicator driver
`timescale 1ns/1ps
module led_status_driver_checker
(
  // watched ports
  input wire sys_clk_i,
  input wire rst_i,
  input wire clk_en_i,
  input wire enumerated_i,
  input wire channel_open_i,
  input wire listen_only_i,
  input wire config_error_i,
  input wire error_warning_i,
  input wire bus_off_i,
  input wire led_yellow_o,
  input wire led_green_o,
  input wire led_red_o,
  input wire tx_inhibit_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // no error condition active
  wire ok = !config_error_i && !error_warning_i && !bus_off_i;

  reset_lamps_a: assert property (disable iff (1'b0) rst_i |=>
    led_yellow_o && led_green_o && !led_red_o) else $error("reset lamps");
  tx_gate_a: assert property (
    tx_inhibit_o == (channel_open_i && listen_only_i)) else $error("tx gate");
  bus_off_a: assert property (
    (bus_off_i && clk_en_i)[*4] |-> led_red_o) else $error("bus off");
  red_off_a: assert property (
    (ok && clk_en_i)[*4] |-> !led_red_o) else $error("red off");
  green_on_a: assert property (
    (channel_open_i && !listen_only_i && clk_en_i)[*4] |-> led_green_o)
    else $error("green on");
  yellow_a: assert property (
    (clk_en_i && $stable(enumerated_i))[*3] |-> led_yellow_o == enumerated_i)
    else $error("yellow");
  freeze_a: assert property (
    !clk_en_i |=> $stable({led_yellow_o, led_green_o, led_red_o}))
    else $error("freeze");
  flicker_min_a: assert property (
    $rose(led_green_o) && channel_open_i && listen_only_i
    |-> !$fell(led_green_o) throughout ##195 1) else $error("flicker");
endmodule

bind led_status_driver led_status_driver_checker chk (.*);

// file: bench/test_led_status_driver.sv
// self-checking bench for the status indicator driver
`timescale 1ns/1ps
`define CHK(n,e,s) n_checks++; if ((s) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s exp %0d got %0d", n, e, s); end
module test_led_status_driver;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [8:0] st = 9'h100; // en enum init closed open listen cfg warn off
  wire        y, g, r, tx;
  logic       b;
  int         g_on, g_off, r_on, r_off, n_mismatch = 0, n_checks = 0;

  // design with a 4-clock millisecond tick
  led_status_driver #(.TICK_CYCLES(4)) dut (.sys_clk_i(clk), .rst_i(rst),
    .clk_en_i(st[8]), .enumerated_i(st[7]), .channel_initialised_i(st[6]),
    .channel_closed_i(st[5]), .channel_open_i(st[4]), .listen_only_i(st[3]),
    .config_error_i(st[2]), .error_warning_i(st[1]), .bus_off_i(st[0]),
    .led_yellow_o(y), .led_green_o(g), .led_red_o(r), .tx_inhibit_o(tx));
  led_lamp_model gm (.clk_i(clk), .lamp_i(g), .on_len_o(g_on),
    .off_len_o(g_off));
  led_lamp_model rm (.clk_i(clk), .lamp_i(r), .on_len_o(r_on),
    .off_len_o(r_off));

  // apply a status word at the falling edge and let it run
  task go(input logic [8:0] v, input int n);
    @(negedge clk);
    st = v;
    repeat (n) @(negedge clk);
  endtask
  task t_green;
    go(9'h1c0, 4000);
    `CHK("blink on", 800, g_on)
    `CHK("blink off", 800, g_off)
    `CHK("yellow", 1'b1, y)
    go(9'h198, 1000);
    `CHK("flick on", 200, g_on)
    `CHK("flick off", 200, g_off)
    `CHK("tx", 1'b1, tx)
    go(9'h190, 1000);
    `CHK("open", 1'b1, g)
    `CHK("tx off", 1'b0, tx)
    go(9'h1a0, 11000);
    `CHK("single on", 800, g_on)
    `CHK("single off", 4000, g_off)
  endtask
  task t_red;
    go(9'h1a4, 4000);
    `CHK("cfg on", 800, r_on)
    go(9'h0a4, 1);
    b = r;
    go(9'h0a4, 100);
    `CHK("frozen", b, r)
    go(9'h1a6, 11000);
    `CHK("warn off", 4000, r_off)
    `CHK("warn on", 800, r_on)
    go(9'h1a3, 20);
    `CHK("bus off", 1'b1, r)
    go(9'h100, 10);
    `CHK("unenum", 1'b0, y)
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // clock
  initial forever #25 clk = ~clk;
  // watchdog
  initial
  begin
    #3000000;
    n_mismatch++;
    final_report;
  end
  // main sequence
  initial
  begin
    repeat (12) @(negedge clk);
    `CHK("rst y", 1'b1, y)
    `CHK("rst g", 1'b1, g)
    `CHK("rst r", 1'b0, r)
    rst = 1'b0;
    t_green;
    t_red;
    final_report;
  end
endmodule
